// ==== core/pzd_defines.svh ====
`ifndef PZD_DEFINES_SVH
`define PZD_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PZD_ADDR_W 12
`define PZD_IDX_THRESH 10'h01A
`define PZD_IDX_RBKCTL 10'h01D
`define PZD_IDX_ZD 10'h01E
`define PZD_IDX_STATUS 10'h01F
`define PZD_IDX_IRQST 10'h040
`define PZD_IDX_IRQMASK 10'h041

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PZD_THR_SEL_BIT 6
`define PZD_RBK_DIS_BIT 4
`define PZD_ZD_EXT_BIT 2
`define PZD_ZD_EN_BIT 1

// live status vector, same layout as the status readback register
`define PZD_ST_W 7
`define PZD_LV_CAL 6
`define PZD_LV_HOLD 5
`define PZD_LV_REFERENCE_INPUT_TWO 4
`define PZD_LV_LOCK 0

// interrupt event bits
`define PZD_EV_W 5
`define PZD_EV_CAL 0
`define PZD_EV_HOLD 1
`define PZD_EV_LOCK 2
`define PZD_EV_UNLOCK 3
`define PZD_EV_REFCHG 4

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define PZD_ZD_EN_RESET 1'h0
`define PZD_ZD_EXT_RESET 1'h0
`define PZD_THR_SEL_RESET 1'h0
`define PZD_RBK_DIS_RESET 1'h0
`define PZD_STATUS_RESET 7'h00
`define PZD_IRQ_RESET 5'h00
`define PZD_RESP_OKAY 2'h0
`define PZD_RESP_DECERR 2'h3

`endif

// ==== core/pzd_pkg.sv ====
package pzd_pkg;

    // register selected by an address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_THRESH = 3'b001,
        SEL_RBKCTL = 3'b010,
        SEL_ZD = 3'b011,
        SEL_STATUS = 3'b100,
        SEL_IRQST = 3'b101,
        SEL_IRQMASK = 3'b110
    } pzd_sel_e;

    // write channel progress
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b00,
        WR_RESP = 2'b01
    } pzd_wr_e;

    typedef struct packed {
        logic [6:0] stage1;
        logic [6:0] stage2;
    } pzd_sync_s;

    typedef struct packed {
        logic awHave;
        logic [9:0] awIdx;
        logic wHave;
        logic [7:0] wData;
        logic wLane0;
        pzd_wr_e wrState;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic thrSel;
        logic rbkDisable;
        logic zdEnable;
        logic zdExternal;
        logic zdIntMode;
        logic zdExtMode;
        logic [6:0] pllStatus;
        logic [6:0] prevLive;
        logic [4:0] irqStatus;
        logic [4:0] irqMask;
    } pzd_state_s;

endpackage

// ==== core/pzd_status_if.sv ====
`timescale 1ns/10ps

// synchronised live status between the synchroniser and the register bank
interface pzd_status_if;
    logic [6:0] live;

    modport source (output live);
    modport sink (input live);
endinterface

// ==== core/pzd_status_sync.sv ====
`timescale 1ns/10ps

module pzd_status_sync (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [6:0] statusRaw,
    pzd_status_if.source statusBus
);

    pzd_pkg::pzd_sync_s st;
    pzd_pkg::pzd_sync_s next_st;

    // two flops per bit; only the second stage is visible
    always_comb begin
        next_st = st;
        next_st.stage1 = statusRaw;
        next_st.stage2 = st.stage1;
    end

    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign statusBus.live = st.stage2;

endmodule // pzd_status_sync

// ==== core/pzd_regs.sv ====
`timescale 1ns/10ps
`include "pzd_defines.svh"

// What this block does
// - zero-delay bit 2 picks internal (0) or external (1), only while enabled
// - zero-delay bit 1 enables the function; resets to 0, disabled
// - status bit 6 shows VCO calibration finished; software writes are ignored
// - status bit 5 shows the live holdover state, not the holdover enable
// - status bit 4 is 1 for reference input two, 0 for input one
// - status bit 3 is 1 while VCO frequency is above its threshold
// - status bit 2 is 1 while reference two exceeds the selected threshold
// - status bit 1 is 1 while reference one exceeds the selected threshold
// - status bit 0 shows the digital lock detector output
// - readback disable bit freezes the status register at its last capture

module pzd_regs (
    input wire logic core_clk,
    input wire logic nrst,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // live status from the pll monitors, asynchronous
    input wire logic calFinished,
    input wire logic inHoldover,
    input wire logic referenceInputTwoSelected,
    input wire logic vcoAboveThreshold,
    input wire logic referenceInputTwoAboveThreshold,
    input wire logic referenceInputOneAboveThreshold,
    input wire logic digitalLock,
    // control to the pll and monitors
    output logic zeroDelayEnable,
    output logic zeroDelayInternalMode,
    output logic zeroDelayExternalMode,
    output logic refThresholdSelect,
    output logic irq
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------

    // map a word index to a register
    function automatic pzd_pkg::pzd_sel_e decodeSel(input logic [9:0] idx);
        pzd_pkg::pzd_sel_e sel;
        sel = pzd_pkg::SEL_NONE;
        case (idx)
            `PZD_IDX_THRESH: sel = pzd_pkg::SEL_THRESH;
            `PZD_IDX_RBKCTL: sel = pzd_pkg::SEL_RBKCTL;
            `PZD_IDX_ZD: sel = pzd_pkg::SEL_ZD;
            `PZD_IDX_STATUS: sel = pzd_pkg::SEL_STATUS;
            `PZD_IDX_IRQST: sel = pzd_pkg::SEL_IRQST;
            `PZD_IDX_IRQMASK: sel = pzd_pkg::SEL_IRQMASK;
            default: sel = pzd_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction

    // ----------------------------------------------------------------
    // status synchroniser
    // ----------------------------------------------------------------

    pzd_status_if statusBus ();

    // bits ordered as the status readback register
    pzd_status_sync u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .statusRaw({calFinished, inHoldover, referenceInputTwoSelected, vcoAboveThreshold,
                    referenceInputTwoAboveThreshold, referenceInputOneAboveThreshold, digitalLock}),
        .statusBus(statusBus)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------

    pzd_pkg::pzd_state_s st;
    pzd_pkg::pzd_state_s next_st;
    logic [6:0] live;
    logic awTake;
    logic wTake;
    logic arTake;
    logic [4:0] events;
    logic [4:0] irqClear;
    pzd_pkg::pzd_sel_e wrSel;
    pzd_pkg::pzd_sel_e rdSel;
    logic [31:0] rdWord;

    assign live = statusBus.live;

    // handshake terms
    assign awready = !st.awHave && (st.wrState == pzd_pkg::WR_COLLECT);
    assign wready = !st.wHave && (st.wrState == pzd_pkg::WR_COLLECT);
    assign arready = !st.rvalid;
    assign awTake = awvalid && awready;
    assign wTake = wvalid && wready;
    assign arTake = arvalid && arready;
    assign wrSel = decodeSel(st.awIdx);
    assign rdSel = decodeSel(araddr[11:2]);

    // events from the live status, edge detected on synchronised bits
    always_comb begin
        events = '0;
        events[`PZD_EV_CAL] = live[`PZD_LV_CAL] && !st.prevLive[`PZD_LV_CAL];
        events[`PZD_EV_HOLD] = live[`PZD_LV_HOLD] && !st.prevLive[`PZD_LV_HOLD];
        events[`PZD_EV_LOCK] = live[`PZD_LV_LOCK] && !st.prevLive[`PZD_LV_LOCK];
        events[`PZD_EV_UNLOCK] = !live[`PZD_LV_LOCK] && st.prevLive[`PZD_LV_LOCK];
        events[`PZD_EV_REFCHG] = live[`PZD_LV_REFERENCE_INPUT_TWO] ^ st.prevLive[`PZD_LV_REFERENCE_INPUT_TWO];
    end

    // ----------------------------------------------------------------
    // read data mux
    // ----------------------------------------------------------------

    // unused and reserved bits read as zero
    always_comb begin
        rdWord = '0;
        irqClear = '0;
        case (rdSel)
            pzd_pkg::SEL_THRESH: begin
                rdWord[`PZD_THR_SEL_BIT] = st.thrSel;
            end
            pzd_pkg::SEL_RBKCTL: begin
                rdWord[`PZD_RBK_DIS_BIT] = st.rbkDisable;
            end
            pzd_pkg::SEL_ZD: begin
                rdWord[`PZD_ZD_EXT_BIT] = st.zdExternal;
                rdWord[`PZD_ZD_EN_BIT] = st.zdEnable;
            end
            pzd_pkg::SEL_STATUS: begin
                rdWord[6:0] = st.pllStatus;
            end
            pzd_pkg::SEL_IRQST: begin
                rdWord[4:0] = st.irqStatus;
                irqClear = arTake ? st.irqStatus : 5'h00;
            end
            pzd_pkg::SEL_IRQMASK: begin
                rdWord[4:0] = st.irqMask;
            end
            default: begin
                rdWord = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    always_comb begin
        next_st = st;

        // status capture unless readback is disabled
        if (!st.rbkDisable) begin
            next_st.pllStatus[`PZD_LV_CAL] = live[`PZD_LV_CAL];
            next_st.pllStatus[`PZD_LV_HOLD] = live[`PZD_LV_HOLD];
            next_st.pllStatus[`PZD_LV_REFERENCE_INPUT_TWO] = live[`PZD_LV_REFERENCE_INPUT_TWO];
            next_st.pllStatus[3] = live[3];
            next_st.pllStatus[2] = live[2];
            next_st.pllStatus[1] = live[1];
            next_st.pllStatus[`PZD_LV_LOCK] = live[`PZD_LV_LOCK];
        end
        next_st.prevLive = live;

        // sticky interrupt bits; a new event wins over a read clear
        next_st.irqStatus = (st.irqStatus & ~irqClear) | events;

        // write address and data collected in either order
        if (awTake) begin
            next_st.awHave = 1'b1;
            next_st.awIdx = awaddr[11:2];
        end
        if (wTake) begin
            next_st.wHave = 1'b1;
            next_st.wData = wdata[7:0];
            next_st.wLane0 = wstrb[0];
        end

        // write sequencing
        case (st.wrState)
            pzd_pkg::WR_COLLECT: begin
                if (st.awHave && st.wHave) begin
                    next_st.awHave = 1'b0;
                    next_st.wHave = 1'b0;
                    next_st.wrState = pzd_pkg::WR_RESP;
                    next_st.bresp = `PZD_RESP_OKAY;
                    case (wrSel)
                        pzd_pkg::SEL_THRESH: begin
                            if (st.wLane0) begin
                                next_st.thrSel = st.wData[`PZD_THR_SEL_BIT];
                            end
                        end
                        pzd_pkg::SEL_RBKCTL: begin
                            if (st.wLane0) begin
                                next_st.rbkDisable = st.wData[`PZD_RBK_DIS_BIT];
                            end
                        end
                        pzd_pkg::SEL_ZD: begin
                            // bit 0 and upper bits are not stored
                            if (st.wLane0) begin
                                next_st.zdEnable = st.wData[`PZD_ZD_EN_BIT];
                                next_st.zdExternal = st.wData[`PZD_ZD_EXT_BIT];
                            end
                        end
                        pzd_pkg::SEL_STATUS: begin
                            next_st.bresp = `PZD_RESP_OKAY;
                        end
                        pzd_pkg::SEL_IRQST: begin
                            next_st.bresp = `PZD_RESP_OKAY;
                        end
                        pzd_pkg::SEL_IRQMASK: begin
                            if (st.wLane0) begin
                                next_st.irqMask = st.wData[4:0];
                            end
                        end
                        default: begin
                            next_st.bresp = `PZD_RESP_DECERR;
                        end
                    endcase
                end
            end
            pzd_pkg::WR_RESP: begin
                if (bready) begin
                    next_st.wrState = pzd_pkg::WR_COLLECT;
                end
            end
            default: begin
                next_st.wrState = pzd_pkg::WR_COLLECT;
            end
        endcase

        // zero-delay mode outputs follow the stored control bits
        next_st.zdIntMode = next_st.zdEnable && !next_st.zdExternal;
        next_st.zdExtMode = next_st.zdEnable && next_st.zdExternal;

        // read channel
        if (arTake) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rdWord;
            next_st.rresp = (rdSel == pzd_pkg::SEL_NONE) ? `PZD_RESP_DECERR : `PZD_RESP_OKAY;
        end else if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.wrState <= pzd_pkg::WR_COLLECT;
            st.bresp <= `PZD_RESP_OKAY;
            st.rresp <= `PZD_RESP_OKAY;
            st.thrSel <= `PZD_THR_SEL_RESET;
            st.rbkDisable <= `PZD_RBK_DIS_RESET;
            st.zdEnable <= `PZD_ZD_EN_RESET;
            st.zdExternal <= `PZD_ZD_EXT_RESET;
            st.pllStatus <= `PZD_STATUS_RESET;
            st.irqStatus <= `PZD_IRQ_RESET;
            st.irqMask <= `PZD_IRQ_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    assign bvalid = (st.wrState == pzd_pkg::WR_RESP);
    assign bresp = st.bresp;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign zeroDelayEnable = st.zdEnable;
    assign zeroDelayInternalMode = st.zdIntMode;
    assign zeroDelayExternalMode = st.zdExtMode;
    assign refThresholdSelect = st.thrSel;
    assign irq = |(st.irqStatus & st.irqMask);

endmodule // pzd_regs

// ==== testbench/pzd_regs_checker.sv ====
`timescale 1ns/10ps

module pzd_regs_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic bvalid,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [11:0] araddr,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic calFinished,
    input wire logic inHoldover,
    input wire logic referenceInputTwoSelected,
    input wire logic vcoAboveThreshold,
    input wire logic referenceInputTwoAboveThreshold,
    input wire logic referenceInputOneAboveThreshold,
    input wire logic digitalLock,
    input wire logic zeroDelayEnable,
    input wire logic zeroDelayInternalMode,
    input wire logic zeroDelayExternalMode,
    input wire logic refThresholdSelect
);
    // live monitor levels in status register order
    logic [6:0] liveVec;
    assign liveVec = {calFinished, inHoldover, referenceInputTwoSelected, vcoAboveThreshold,
        referenceInputTwoAboveThreshold, referenceInputOneAboveThreshold, digitalLock};

    // readback disable as last written, committed one edge after both halves are taken
    logic awSeen;
    logic awHit;
    logic wSeen;
    logic wBit;
    logic wLane;
    logic rbkOff;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            awSeen <= 1'h0;
            awHit <= 1'h0;
            wSeen <= 1'h0;
            wBit <= 1'h0;
            wLane <= 1'h0;
            rbkOff <= 1'h0;
        end else if (awSeen && wSeen) begin
            awSeen <= 1'h0;
            wSeen <= 1'h0;
            if (awHit && wLane) begin
                rbkOff <= wBit;
            end
        end else begin
            if (awvalid && awready) begin
                awSeen <= 1'h1;
                awHit <= (awaddr[11:2] == 10'h01D);
            end
            if (wvalid && wready) begin
                wSeen <= 1'h1;
                wBit <= wdata[4];
                wLane <= wstrb[0];
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------
    sequence s_steady;
        (!rbkOff && $stable(liveVec)) [*8];
    endsequence
    sequence s_rd_take(logic [11:0] a);
        arvalid && arready && araddr == a;
    endsequence
    property p_mode_en;
        (zeroDelayInternalMode || zeroDelayExternalMode) |-> zeroDelayEnable;
    endproperty
    property p_en_mode;
        zeroDelayEnable |-> zeroDelayInternalMode != zeroDelayExternalMode;
    endproperty
    property p_en_write;
        $changed(zeroDelayEnable) |-> $rose(bvalid);
    endproperty
    property p_ext_write;
        $changed(zeroDelayExternalMode) |-> $rose(bvalid);
    endproperty
    property p_thr_write;
        $changed(refThresholdSelect) |-> $rose(bvalid);
    endproperty
    property p_unused;
        rvalid |-> rdata[31:7] == 25'h0;
    endproperty
    property p_zd_read;
        s_rd_take(12'h078) |=> rvalid && rdata[1:0] == {zeroDelayEnable, 1'h0};
    endproperty
    property p_status_live;
        s_steady ##0 s_rd_take(12'h07C) |=> rdata[6:0] == $past(liveVec);
    endproperty

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_mode_en: assert property (p_mode_en)
        else $error("mode active while disabled");
    a_en_mode: assert property (p_en_mode)
        else $error("not exactly one mode while enabled");
    a_en_write: assert property (p_en_write)
        else $error("enable moved without a write");
    a_ext_write: assert property (p_ext_write)
        else $error("external mode moved without a write");
    a_thr_write: assert property (p_thr_write)
        else $error("threshold select moved without a write");
    a_unused: assert property (p_unused)
        else $error("unused read bits set");
    a_zd_read: assert property (p_zd_read)
        else $error("zero delay readback wrong");
    a_status_live: assert property (p_status_live)
        else $error("status readback differs from steady inputs");
endmodule // pzd_regs_checker

bind pzd_regs pzd_regs_checker i_pzd_regs_checker (.core_clk, .nrst, .bvalid, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .arvalid, .arready, .araddr,
    .rvalid, .rdata, .calFinished, .inHoldover, .referenceInputTwoSelected, .vcoAboveThreshold,
    .referenceInputTwoAboveThreshold, .referenceInputOneAboveThreshold, .digitalLock, .zeroDelayEnable,
    .zeroDelayInternalMode, .zeroDelayExternalMode, .refThresholdSelect);

// ==== testbench/test_pll_zero_delay_and_status_regs.sv ====
`timescale 1ns/10ps

module test_pll_zero_delay_and_status_regs;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic core_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic zeroDelayEnable, zeroDelayInternalMode, zeroDelayExternalMode, refThresholdSelect;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp;
    logic [6:0] live;
    logic [33:0] q[$];
    int errCount = 0;
    int compares = 0;
    int cyc = 0;

    // 25 MHz clock
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end

    pzd_regs i_pzd_regs (.core_clk, .nrst, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
        .rready, .rdata, .rresp, .calFinished(live[6]), .inHoldover(live[5]), .referenceInputTwoSelected(live[4]),
        .vcoAboveThreshold(live[3]), .referenceInputTwoAboveThreshold(live[2]),
        .referenceInputOneAboveThreshold(live[1]), .digitalLock(live[0]), .zeroDelayEnable,
        .zeroDelayInternalMode, .zeroDelayExternalMode, .refThresholdSelect, .irq);

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task endSim;
        if (errCount == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // response watcher takes the oldest note
    always @(posedge core_clk) begin
        if (rvalid && rready) chk({rresp, rdata}, q.pop_front());
        else if (bvalid && bready) chk({bresp, 32'h0}, q.pop_front());
    end

    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            errCount++;
            endSim();
        end
    end

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
        @(posedge core_clk);
        q.push_back({r, 32'h0});
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= v;
        bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        @(posedge core_clk);
        q.push_back(e);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
    endtask

    // new monitor levels, then room for sync and capture
    task automatic settle(input logic [6:0] v);
        live <= v;
        repeat (4) @(posedge core_clk);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, live} = 63'h0;
        void'($urandom(32'h9C65));
        repeat (12) @(posedge core_clk);
        nrst <= 1'h1;
        rd(12'h078, 34'h0);
        // interrupt raised, cleared by read, masked
        wr(12'h104, 32'h4, 2'h0);
        settle(7'h01);
        chk(irq, 34'h1);
        rd(12'h100, 34'h4);
        chk(irq, 34'h0);
        wr(12'h104, 32'h0, 2'h0);
        settle(7'h00);
        chk(irq, 34'h0);
        rd(12'h100, 34'h8);
        rd(12'h100, 34'h0);
        // every zero delay setting with random upper bits
        for (int i = 0; i < 4; i++) begin
            d = ($urandom() & 32'hFFFFFFF9) | (i << 1);
            wr(12'h078, d, 2'h0);
            chk({zeroDelayExternalMode, zeroDelayInternalMode, zeroDelayEnable}, {d[2] & d[1], !d[2] & d[1], d[1]});
            rd(12'h078, {2'h0, d & 32'h6});
        end
        // mid-run reset returns the control bits to their defaults
        nrst <= 1'h0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'h1;
        rd(12'h078, 34'h0);
        chk({zeroDelayExternalMode, zeroDelayInternalMode, zeroDelayEnable}, 34'h0);
        wr(12'h068, 32'h40, 2'h0);
        chk(refThresholdSelect, 34'h1);
        rd(12'h068, 34'h40);
        // each status bit alone, then random patterns
        for (int k = 0; k < 10; k++) begin
            d = (k < 7) ? (32'h1 << k) : $urandom();
            settle(d[6:0]);
            rd(12'h07C, {27'h0, d[6:0]});
        end
        wr(12'h07C, 32'hFF, 2'h0);
        repeat (8) @(posedge core_clk);
        rd(12'h07C, {27'h0, d[6:0]});
        // readback disable holds the last capture
        wr(12'h074, 32'h10, 2'h0);
        rd(12'h074, 34'h10);
        settle(~d[6:0]);
        rd(12'h07C, {27'h0, d[6:0]});
        wr(12'h074, 32'h0, 2'h0);
        settle(~d[6:0]);
        rd(12'h07C, {27'h0, ~d[6:0]});
        // unmapped place
        wr(12'h200, 32'h1, 2'h3);
        rd(12'h200, {2'h3, 32'h0});
        endSim();
    end
endmodule // test_pll_zero_delay_and_status_regs
